// ===== common/angle_abz_pkg.sv
/*
  Shared constants for the angle sensor output logic: register offsets,
  field positions, reset values, serial commands and timing figures.
  Assumes a 250 MHz system clock and a 5-bit address space of 8-bit registers.
*/
package angle_abz_pkg;
  // Register offsets on the serial port.
  localparam logic [4:0] ADDR_BCT    = 5'h03;
  localparam logic [4:0] ADDR_SHAPE  = 5'h04;
  localparam logic [4:0] ADDR_PHIGH  = 5'h05;
  localparam logic [4:0] ADDR_THRESH = 5'h06;
  localparam logic [4:0] ADDR_TRIM   = 5'h09;
  localparam logic [4:0] ADDR_FILTER = 5'h0e;
  localparam logic [4:0] ADDR_STATUS = 5'h1b;
  // Reset values.
  localparam logic [7:0] RST_BCT    = 8'h00;
  localparam logic [7:0] RST_SHAPE  = 8'hc0;
  localparam logic [7:0] RST_PHIGH  = 8'hff;
  localparam logic [7:0] RST_THRESH = 8'h1c;
  localparam logic [7:0] RST_TRIM   = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'h77;
  // Field positions.
  localparam int PLOW_LSB  = 6;
  localparam int SHAPE_LSB = 2;
  localparam int LOWT_LSB  = 5;
  localparam int HIGHT_LSB = 2;
  localparam int STAT_HIGH = 7;
  localparam int STAT_LOW  = 6;
  localparam int TRIM_X    = 0;
  localparam int TRIM_Y    = 1;
  // Serial commands and frame length.
  localparam logic [2:0] CMD_READ   = 3'h2;
  localparam logic [2:0] CMD_WRITE  = 3'h4;
  localparam int         FRAME_BITS = 16;
  // Field thresholds and hysteresis in mT.
  localparam logic [7:0] HYST_MT = 8'h06;
  // Filter window codes and time constant.
  localparam logic [7:0] FW_MIN     = 8'h33;
  localparam logic [7:0] FW_STEP    = 8'h11;
  localparam logic [3:0] FW_LAST    = 4'h8;
  localparam logic [14:0] TAU_MIN_US = 15'h0040;
  // Clock rates in MHz; the ABZ update rate sets the least edge spacing.
  localparam int CLK_MHZ = 250;
  localparam int ABZ_MHZ = 16;

  // Rising-field trip level for a 3-bit threshold code.
  function automatic logic [7:0] thr_rise(input logic [2:0] code);
    case (code)
      3'h0: thr_rise = 8'h1a;
      3'h1: thr_rise = 8'h29;
      3'h2: thr_rise = 8'h38;
      3'h3: thr_rise = 8'h46;
      3'h4: thr_rise = 8'h54;
      3'h5: thr_rise = 8'h62;
      3'h6: thr_rise = 8'h70;
      default: thr_rise = 8'h7e;
    endcase
  endfunction : thr_rise

  // Falling-field trip level lies the hysteresis below the rising one.
  function automatic logic [7:0] thr_fall(input logic [2:0] code);
    thr_fall = thr_rise(code) - HYST_MT;
  endfunction : thr_fall

  // Start-up time in microseconds per filter step (0.5 ms to 264 ms).
  function automatic logic [18:0] startup_us(input logic [3:0] idx);
    case (idx)
      4'h0: startup_us = 19'h0_01f4;
      4'h1: startup_us = 19'h0_044c;
      4'h2: startup_us = 19'h0_09c4;
      4'h3: startup_us = 19'h0_157c;
      4'h4: startup_us = 19'h0_2ee0;
      4'h5: startup_us = 19'h0_6590;
      4'h6: startup_us = 19'h0_dea8;
      4'h7: startup_us = 19'h1_e078;
      default: startup_us = 19'h4_0740;
    endcase
  endfunction : startup_us
endpackage : angle_abz_pkg

// ===== hdl/angle_abz_core.sv
/*
  Output and configuration logic of a contactless angle sensor: register
  file behind the serial port, quadrature and index generation, field flags,
  filter window selection, start-up timing and axis bias-trim enables.
  Assumes angle and field_mt come from the front end, synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - X trim enable set applies bias reduction to X Hall element, else off.
// - Y trim enable set applies bias reduction to Y Hall element, else off.
// - Both enables set reduce both axes equally, no side-shaft correction.
// - Low flag below low threshold, high flag above high threshold.
// - Both flags switch with about 6 mT hysteresis.
// - Thresholds: low in bits 7..5, high in bits 4..2 of register 6.
// - Codes map monotonically from 26/20 mT up to 126/120 mT.
// - Low code above high code is accepted unchanged.
// - Status register 27: high flag bit 7, low flag bit 6.
// - High flag also drives a dedicated output pin continuously.
// - Status contents return in the following frame, not the same one.
// - Filter code 51 gives 64 us, doubling per step to code 187.
// - Start-up time grows with filter window, 0.5 ms to 264 ms.
// - Quadrature outputs emulate a 12-bit incremental encoder.
// - B is shifted a quarter A period from A.
// - A gives pulse code plus one pulses per turn, four edges each.
// - Pulse code resets to 1023.
// - Pulse code low two bits in 0x4 bits 7..6, upper eight in 0x5.
// - Index pulses once per turn at zero, shaped by 4-bit field in 0x4.
// - Default shape: index rises with B falling, lasts half a pulse.
// - Quadrature and index state recomputed at 16 MHz.
module angle_abz_core #(
  parameter int CYCLES_PER_US = angle_abz_pkg::CLK_MHZ
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe_n,
  input  wire logic [15:0] angle,
  input  wire logic [7:0]  field_mt,
  output logic             quad_a,
  output logic             quad_b,
  output logic             index_z,
  output logic             field_high_pin,
  output logic [7:0]       x_trim_amount,
  output logic [7:0]       y_trim_amount,
  output logic [7:0]       filter_window_code,
  output logic [14:0]      filter_tau_us,
  output logic             output_valid
);
  // Register file.
  logic [7:0] bct_q, shape_q, phigh_q, thresh_q, trim_q, filt_q;
  logic [7:0] bct_d, shape_d, phigh_d, thresh_d, trim_d, filt_d;
  logic       rx_valid;
  logic [2:0] rx_cmd;
  logic [4:0] rx_addr;
  logic [7:0] rx_data;
  logic [7:0] rdata;
  logic       field_low_flag, field_high_flag;
  logic [9:0] pulse_count_code;
  logic [3:0] index_shape_code;
  logic [2:0] low_field_threshold, high_field_threshold;
  logic       x_axis_trim_en, y_axis_trim_en;

  serial_reg_port u_port (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .mosi      (mosi),
    .miso      (miso),
    .miso_oe_n (miso_oe_n),
    .rx_valid  (rx_valid),
    .rx_cmd    (rx_cmd),
    .rx_addr   (rx_addr),
    .rx_data   (rx_data),
    .tx_data   (rdata)
  );

  assign pulse_count_code     = {phigh_q, shape_q[angle_abz_pkg::PLOW_LSB +: 2]};
  assign index_shape_code     = shape_q[angle_abz_pkg::SHAPE_LSB +: 4];
  assign low_field_threshold  = thresh_q[angle_abz_pkg::LOWT_LSB +: 3];
  assign high_field_threshold = thresh_q[angle_abz_pkg::HIGHT_LSB +: 3];
  assign x_axis_trim_en       = trim_q[angle_abz_pkg::TRIM_X];
  assign y_axis_trim_en       = trim_q[angle_abz_pkg::TRIM_Y];

  // Read mux; unused addresses and unused status bits read as zero.
  always_comb begin
    rdata = 8'h00;
    case (rx_addr)
      angle_abz_pkg::ADDR_BCT:    rdata = bct_q;
      angle_abz_pkg::ADDR_SHAPE:  rdata = shape_q;
      angle_abz_pkg::ADDR_PHIGH:  rdata = phigh_q;
      angle_abz_pkg::ADDR_THRESH: rdata = thresh_q;
      angle_abz_pkg::ADDR_TRIM:   rdata = trim_q;
      angle_abz_pkg::ADDR_FILTER: rdata = filt_q;
      angle_abz_pkg::ADDR_STATUS: begin
        rdata[angle_abz_pkg::STAT_HIGH] = field_high_flag;
        rdata[angle_abz_pkg::STAT_LOW]  = field_low_flag;
      end
      default: rdata = 8'h00;
    endcase
  end

  // Writes store as given; no cross-check between the two threshold codes.
  always_comb begin
    bct_d    = bct_q;
    shape_d  = shape_q;
    phigh_d  = phigh_q;
    thresh_d = thresh_q;
    trim_d   = trim_q;
    filt_d   = filt_q;
    if (rx_valid && rx_cmd == angle_abz_pkg::CMD_WRITE) begin
      case (rx_addr)
        angle_abz_pkg::ADDR_BCT:    bct_d = rx_data;
        angle_abz_pkg::ADDR_SHAPE:  shape_d = rx_data;
        angle_abz_pkg::ADDR_PHIGH:  phigh_d = rx_data;
        angle_abz_pkg::ADDR_THRESH: thresh_d = rx_data;
        angle_abz_pkg::ADDR_TRIM:   trim_d = rx_data;
        angle_abz_pkg::ADDR_FILTER: filt_d = rx_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bct_q    <= angle_abz_pkg::RST_BCT;
      shape_q  <= angle_abz_pkg::RST_SHAPE;
      phigh_q  <= angle_abz_pkg::RST_PHIGH;
      thresh_q <= angle_abz_pkg::RST_THRESH;
      trim_q   <= angle_abz_pkg::RST_TRIM;
      filt_q   <= angle_abz_pkg::RST_FILTER;
    end else begin
      bct_q    <= bct_d;
      shape_q  <= shape_d;
      phigh_q  <= phigh_d;
      thresh_q <= thresh_d;
      trim_q   <= trim_d;
      filt_q   <= filt_d;
    end
  end

  // Field flags; the high flag feeds the pin straight from its flop.
  field_flag_cmp #(.ABOVE(1'b0)) u_low (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .field_mt (field_mt),
    .code     (low_field_threshold),
    .flag_q   (field_low_flag)
  );
  field_flag_cmp #(.ABOVE(1'b1)) u_high (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .field_mt (field_mt),
    .code     (high_field_threshold),
    .flag_q   (field_high_flag)
  );
  assign field_high_pin = field_high_flag;

  // Trim: each enable gates the same amount, so both set means equal cut.
  logic [7:0] xtrim_d, ytrim_d;
  always_comb begin
    xtrim_d = x_axis_trim_en ? bct_q : 8'h00;
    ytrim_d = y_axis_trim_en ? bct_q : 8'h00;
  end

  // Filter window: step index from the code, clamped to the table.
  logic [3:0]  fw_idx;
  logic [7:0]  fw_off;
  logic [14:0] tau_d;
  always_comb begin
    fw_off = (filt_q > angle_abz_pkg::FW_MIN) ? filt_q - angle_abz_pkg::FW_MIN : 8'h00;
    fw_idx = 4'(fw_off / angle_abz_pkg::FW_STEP);
    if (fw_idx > angle_abz_pkg::FW_LAST) fw_idx = angle_abz_pkg::FW_LAST;
    tau_d = angle_abz_pkg::TAU_MIN_US << fw_idx;
  end

  // Start-up timer in microseconds; the table is picked by the live window.
  logic [7:0]  us_div_q, us_div_d;
  logic [18:0] us_cnt_q, us_cnt_d;
  logic        valid_d;
  always_comb begin
    us_div_d = us_div_q + 8'h01;
    us_cnt_d = us_cnt_q;
    if (us_div_q == 8'(CYCLES_PER_US - 1)) begin
      us_div_d = 8'h00;
      if (!output_valid) us_cnt_d = us_cnt_q + 19'h0_0001;
    end
    valid_d = output_valid || (us_cnt_q >= angle_abz_pkg::startup_us(fw_idx));
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      x_trim_amount      <= 8'h00;
      y_trim_amount      <= 8'h00;
      filter_window_code <= angle_abz_pkg::RST_FILTER;
      filter_tau_us      <= 15'h0000;
      us_div_q           <= 8'h00;
      us_cnt_q           <= 19'h0_0000;
      output_valid       <= 1'b0;
    end else begin
      x_trim_amount      <= xtrim_d;
      y_trim_amount      <= ytrim_d;
      filter_window_code <= filt_q;
      filter_tau_us      <= tau_d;
      us_div_q           <= us_div_d;
      us_cnt_q           <= us_cnt_d;
      output_valid       <= valid_d;
    end
  end

  // Quadrature edge position of an angle for a given pulse code.
  function automatic logic [11:0] edge_of(input logic [15:0] ang, input logic [9:0] code);
    logic [12:0] edges;
    logic [28:0] prod;
    edges   = (13'(code) + 13'h0001) << 2;
    prod    = 29'(ang) * 29'(edges);
    edge_of = prod[27:16];
  endfunction : edge_of

  // Update tick at the ABZ rate by a fractional accumulator.
  localparam logic [7:0] ACC_ADD = 8'(angle_abz_pkg::ABZ_MHZ);
  localparam logic [7:0] ACC_MOD = 8'(angle_abz_pkg::CLK_MHZ);
  // The sum is one bit wider so that a carry past 255 is never lost.
  logic [7:0] acc_q, acc_d;
  logic [8:0] acc_sum;
  logic       tick;
  always_comb begin
    acc_sum = {1'b0, acc_q} + {1'b0, ACC_ADD};
    tick    = (acc_sum >= {1'b0, ACC_MOD});
    acc_d   = tick ? 8'(acc_sum - {1'b0, ACC_MOD}) : acc_sum[7:0];
  end

  // Edge tracker: one edge per tick toward the target, the short way round.
  // Config takes effect only on a tick, so outputs move on update instants.
  logic [9:0]  ppt_act_q, ppt_act_d;
  logic [3:0]  shp_act_q, shp_act_d;
  logic [11:0] pos_q, pos_d, tgt;
  logic [12:0] edges, diff, zpos, zwid;
  logic        a_d, b_d, z_d;
  always_comb begin
    ppt_act_d = ppt_act_q;
    shp_act_d = shp_act_q;
    pos_d     = pos_q;
    edges     = {ppt_act_q + 10'h001 == 10'h000, ppt_act_q + 10'h001, 2'b00};
    tgt       = edge_of(angle, ppt_act_q);
    diff      = (tgt >= pos_q) ? 13'(tgt) - 13'(pos_q) : 13'(tgt) + edges - 13'(pos_q);
    if (tick) begin
      if (pulse_count_code != ppt_act_q || index_shape_code != shp_act_q) begin
        ppt_act_d = pulse_count_code;
        shp_act_d = index_shape_code;
        pos_d     = edge_of(angle, pulse_count_code);
      end else if (diff != 13'h0000) begin
        if (diff <= (edges >> 1)) pos_d = (13'(pos_q) + 13'h0001 == edges) ? 12'h000 : pos_q + 12'h001;
        else pos_d = (pos_q == 12'h000) ? 12'(edges - 13'h0001) : pos_q - 12'h001;
      end
    end
    // Gray phase: B falls entering phase 0, B leads A by a quarter period.
    a_d = (pos_d[1:0] == 2'h0) || (pos_d[1:0] == 2'h3);
    b_d = pos_d[1];
    // Shape code: low bits shift the start back by edges, high bits set width.
    zpos = 13'(pos_d) + 13'(shp_act_d[1:0]);
    if (zpos >= edges) zpos = zpos - edges;
    case (shp_act_d[3:2])
      2'h0: zwid = 13'h0002;
      2'h1: zwid = 13'h0001;
      2'h2: zwid = 13'h0003;
      default: zwid = 13'h0004;
    endcase
    z_d = (zpos < zwid);
    if (!tick) begin
      a_d = quad_a;
      b_d = quad_b;
      z_d = index_z;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_q     <= 8'h00;
      ppt_act_q <= {angle_abz_pkg::RST_PHIGH, angle_abz_pkg::RST_SHAPE[7:6]};
      shp_act_q <= angle_abz_pkg::RST_SHAPE[5:2];
      pos_q     <= 12'h000;
      quad_a    <= 1'b1;
      quad_b    <= 1'b0;
      index_z   <= 1'b1;
    end else begin
      acc_q     <= acc_d;
      ppt_act_q <= ppt_act_d;
      shp_act_q <= shp_act_d;
      pos_q     <= pos_d;
      quad_a    <= a_d;
      quad_b    <= b_d;
      index_z   <= z_d;
    end
  end

  property p_edge_on_tick;
    @(posedge clk_sys) disable iff (reset)
      !$stable({quad_a, quad_b, index_z}) |-> $past(tick);
  endproperty
  a_edge_on_tick: assert property (p_edge_on_tick)
    else $error("Encoder output changed off an update instant.");

  property p_tick_gap;
    @(posedge clk_sys) disable iff (reset)
      tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("Update instants closer than the ABZ rate allows.");

  property p_one_channel;
    @(posedge clk_sys) disable iff (reset)
      ($stable(ppt_act_q) && $stable(shp_act_q)) |-> !($changed(quad_a) && $changed(quad_b));
  endproperty
  a_one_channel: assert property (p_one_channel)
    else $error("A and B changed together.");

  property p_index_default;
    @(posedge clk_sys) disable iff (reset)
      ($rose(index_z) && shp_act_q == 4'h0 && $stable(ppt_act_q) && $stable(shp_act_q))
        |-> $fell(quad_b);
  endproperty
  a_index_default: assert property (p_index_default)
    else $error("Default index did not rise with B falling.");

  property p_trim_equal;
    @(posedge clk_sys) disable iff (reset)
      (x_axis_trim_en && y_axis_trim_en) ##1 $stable(trim_q) && $stable(bct_q)
        |-> (x_trim_amount == y_trim_amount) && (x_trim_amount == bct_q);
  endproperty
  a_trim_equal: assert property (p_trim_equal)
    else $error("Both trims set but amounts differ.");

  property p_trim_off;
    @(posedge clk_sys) disable iff (reset)
      !x_axis_trim_en ##1 !$past(y_axis_trim_en) |-> x_trim_amount == 8'h00 && y_trim_amount == 8'h00;
  endproperty
  a_trim_off: assert property (p_trim_off)
    else $error("Trim amount driven while its enable is clear.");

  property p_valid_time;
    @(posedge clk_sys) disable iff (reset)
      $rose(output_valid) |-> $past(us_cnt_q) >= angle_abz_pkg::startup_us($past(fw_idx));
  endproperty
  a_valid_time: assert property (p_valid_time)
    else $error("Output marked valid before the start-up time.");
endmodule : angle_abz_core
`default_nettype wire

// ===== hdl/field_flag_cmp.sv
/*
  One field flag with hysteresis against a 3-bit threshold code.
  Assumes the field strength arrives in mT, synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module field_flag_cmp #(
  parameter bit ABOVE = 1'b1
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] field_mt,
  input  wire logic [2:0] code,
  output logic            flag_q
);
  logic       flag_d;
  logic [7:0] rise;
  logic [7:0] fall;

  // Trip on one side of the band and release only past the other side.
  always_comb begin
    rise   = angle_abz_pkg::thr_rise(code);
    fall   = angle_abz_pkg::thr_fall(code);
    flag_d = flag_q;
    if (ABOVE) begin
      if (field_mt > rise) flag_d = 1'b1;
      else if (field_mt < fall) flag_d = 1'b0;
    end else begin
      if (field_mt < fall) flag_d = 1'b1;
      else if (field_mt > rise) flag_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) flag_q <= 1'b0;
    else flag_q <= flag_d;
  end

  property p_flag_trip;
    @(posedge clk_sys) disable iff (reset)
      (ABOVE ? field_mt > rise : field_mt < fall) |=> flag_q;
  endproperty
  a_flag_trip: assert property (p_flag_trip)
    else $error("Field flag did not trip past its threshold.");

  property p_flag_hold;
    @(posedge clk_sys) disable iff (reset)
      (flag_q && field_mt >= fall && field_mt <= rise) |=> flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("Field flag released inside the hysteresis band.");
endmodule : field_flag_cmp
`default_nettype wire

// ===== hdl/serial_reg_port.sv
/*
  Serial register port: 16-bit frames of command, address and value.
  Assumes sclk, cs_n and mosi are synchronous to clk_sys; mode 0 timing.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_reg_port (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe_n,
  output logic            rx_valid,
  output logic [2:0]      rx_cmd,
  output logic [4:0]      rx_addr,
  output logic [7:0]      rx_data,
  input  wire logic [7:0] tx_data
);
  logic        sclk_q, sclk_d;
  logic [15:0] rx_q, rx_d;
  logic [15:0] tx_q, tx_d;
  logic [15:0] resp_q, resp_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        done;

  // Shift on the sampled sclk edges; a read answer waits for the next frame.
  always_comb begin
    sclk_d = sclk;
    rx_d   = rx_q;
    tx_d   = tx_q;
    cnt_d  = cnt_q;
    resp_d = resp_q;
    done   = 1'b0;
    if (cs_n) begin
      cnt_d = 5'h00;
      tx_d  = resp_q;
    end else if (sclk && !sclk_q) begin
      rx_d  = {rx_q[14:0], mosi};
      cnt_d = cnt_q + 5'h01;
      done  = (cnt_q == 5'(angle_abz_pkg::FRAME_BITS - 1));
    end else if (!sclk && sclk_q) begin
      tx_d = {tx_q[14:0], 1'b0};
    end
    if (rx_valid) resp_d = {tx_data, 8'h00};
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclk_q   <= 1'b0;
      rx_q     <= 16'h0000;
      tx_q     <= 16'h0000;
      resp_q   <= 16'h0000;
      cnt_q    <= 5'h00;
      rx_valid <= 1'b0;
    end else begin
      sclk_q   <= sclk_d;
      rx_q     <= rx_d;
      tx_q     <= tx_d;
      resp_q   <= resp_d;
      cnt_q    <= cnt_d;
      rx_valid <= done;
    end
  end

  assign rx_cmd    = rx_q[15:13];
  assign rx_addr   = rx_q[12:8];
  assign rx_data   = rx_q[7:0];
  assign miso      = tx_q[15];
  assign miso_oe_n = cs_n;

  sequence s_frame_end;
    rx_valid ##0 (rx_cmd == angle_abz_pkg::CMD_READ);
  endsequence
  property p_reply_next;
    @(posedge clk_sys) disable iff (reset)
      s_frame_end |=> (resp_q[15:8] == $past(tx_data));
  endproperty
  a_reply_next: assert property (p_reply_next)
    else $error("Read answer not queued for the next frame.");
endmodule : serial_reg_port
`default_nettype wire

// ===== sim/abz_partner.sv
/*
  Motor controller model: decodes the quadrature pair into a position count.
  Assumes A and B are registered outputs sampled on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module abz_partner (
  input  wire logic          clk_sys,
  input  wire logic          quad_a,
  input  wire logic          quad_b,
  output logic signed [15:0] pos_cnt,
  output int                 n_bad
);
  logic [1:0] ph;
  logic [1:0] ph_q = 2'h0;
  int         gap = 0;
  assign ph = {quad_b, ~(quad_a ^ quad_b)};
  initial pos_cnt = 16'sh0000;
  initial n_bad = 0;
  // Count steps; a two-phase jump would lose the direction, so it is flagged.
  always @(posedge clk_sys) begin
    ph_q <= ph;
    gap <= gap + 1;
    if (ph != ph_q) begin
      gap <= 1;
      if (gap < 15) n_bad <= n_bad + 1;
      if (ph - ph_q == 2'h1) pos_cnt <= pos_cnt + 16'sh0001;
      else if (ph - ph_q == 2'h3) pos_cnt <= pos_cnt - 16'sh0001;
      else n_bad <= n_bad + 1;
    end
  end
endmodule : abz_partner
`default_nettype wire

// ===== sim/angle_sensor_abz_and_field_flags_bench.sv
/*
  Self-checking bench for the angle sensor output logic.
  Assumes the core with CYCLES_PER_US of 1 and the quadrature partner model.
*/
`timescale 1ns/1ps
`default_nettype none
module angle_sensor_abz_and_field_flags_bench;
  logic clk_sys, reset, sclk, cs_n, mosi, miso, miso_oe_n, quad_a, quad_b;
  logic index_z, field_high_pin, output_valid, sclk_q, cs_q;
  logic [15:0] angle, pend, cap, e;
  logic [7:0] field_mt, x_trim, y_trim, fw_code;
  logic [14:0] tau;
  logic signed [15:0] pos_cnt, c0;
  int n_bad, b0, n_mismatch, checks_done, cycles, seed, r, p;
  logic [15:0] exp_q[$];
  logic [7:0] fld[6] = '{8'h7f, 8'h79, 8'h77, 8'h13, 8'h15, 8'h1b};
  logic [7:0] st[6] = '{8'h80, 8'h80, 8'h00, 8'h40, 8'h40, 8'h00};
  angle_abz_core #(.CYCLES_PER_US(1)) dut (.clk_sys(clk_sys), .reset(reset),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .angle(angle), .field_mt(field_mt), .quad_a(quad_a), .quad_b(quad_b),
    .index_z(index_z), .field_high_pin(field_high_pin), .x_trim_amount(x_trim),
    .y_trim_amount(y_trim), .filter_window_code(fw_code), .filter_tau_us(tau),
    .output_valid(output_valid));
  abz_partner partner (.clk_sys(clk_sys), .quad_a(quad_a), .quad_b(quad_b),
    .pos_cnt(pos_cnt), .n_bad(n_bad));
  // Free running 250 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic cmp(input string what, input logic [15:0] ex, input logic [15:0] got);
    checks_done++;
    if (got !== ex) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, ex, got);
    end
  endtask : cmp
  // The reply of a frame comes one frame later, so each note is queued a frame late.
  task automatic frame(input logic [15:0] w, input logic [15:0] ex);
    exp_q.push_back(pend);
    pend = ex;
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi <= w[i];
      sclk <= 1'b0;
      tick(4);
      sclk <= 1'b1;
      tick(4);
    end
    sclk <= 1'b0;
    tick(4);
    cmp("miso oe", 16'h0000, {15'h0000, miso_oe_n});
    cs_n <= 1'b1;
    mosi <= ~mosi;
    tick(5);
  endtask : frame
  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] v);
    frame({angle_abz_pkg::CMD_READ, a, 8'h00}, {m, v});
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    frame({angle_abz_pkg::CMD_WRITE, a, v}, 16'h0000);
  endtask : wr
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // Reply monitor: shift miso on sclk rises, compare at the end of each frame.
  always @(posedge clk_sys) begin
    sclk_q <= sclk;
    cs_q <= cs_n;
    if (!cs_n && sclk && !sclk_q) cap <= {cap[14:0], miso};
    if (cs_n && !cs_q) begin
      e = exp_q.pop_front();
      cmp("reply", {8'h00, e[15:8] & e[7:0]}, {8'h00, e[15:8] & cap[15:8]});
    end
  end
  // Hang guard; the whole sequence needs about 4100 cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    seed = 23818;
    {reset, cs_n, sclk_q, cs_q} = 4'hf;
    {sclk, mosi, angle, pend, cap} = '0;
    field_mt = 8'h32;
    tick(4);
    reset <= 1'b0;
    tick(1);
    cmp("miso idle", 16'h0001, {15'h0000, miso_oe_n});
    rd(angle_abz_pkg::ADDR_SHAPE, 8'hff, 8'hc0);
    rd(angle_abz_pkg::ADDR_PHIGH, 8'hff, 8'hff);
    rd(angle_abz_pkg::ADDR_THRESH, 8'hff, 8'h1c);
    rd(angle_abz_pkg::ADDR_FILTER, 8'hff, 8'h77);
    rd(5'h1f, 8'hff, 8'h00);
    cmp("valid early", 16'h0000, {15'h0000, output_valid});
    // Field sweep around both default trip levels, with random depth.
    for (int i = 0; i < 6; i++) begin
      r = {$random(seed)} % 20;
      field_mt <= (i == 0) ? fld[i] + 8'(r * 5) : (i == 3) ? fld[i] - 8'(r) : fld[i];
      tick(2);
      cmp("high pin", {15'h0000, st[i][7]}, {15'h0000, field_high_pin});
      rd(angle_abz_pkg::ADDR_STATUS, 8'hc0, st[i]);
    end
    wr(angle_abz_pkg::ADDR_THRESH, 8'he0);
    rd(angle_abz_pkg::ADDR_THRESH, 8'hff, 8'he0);
    rd(angle_abz_pkg::ADDR_STATUS, 8'hc0, 8'hc0);
    wr(angle_abz_pkg::ADDR_BCT, 8'h56);
    for (int t = 0; t < 4; t++) begin
      wr(angle_abz_pkg::ADDR_TRIM, 8'(t));
      cmp("x trim", t[0] ? 16'h0056 : 16'h0000, {8'h00, x_trim});
      cmp("y trim", t[1] ? 16'h0056 : 16'h0000, {8'h00, y_trim});
    end
    wr(angle_abz_pkg::ADDR_FILTER, 8'h33);
    cmp("tau min", 16'h0040, {1'b0, tau});
    wr(angle_abz_pkg::ADDR_FILTER, 8'hbb);
    cmp("tau max", 16'h4000, {1'b0, tau});
    cmp("window", 16'h00bb, {8'h00, fw_code});
    cmp("valid late", 16'h0001, {15'h0000, output_valid});
    // One pulse per turn, default index shape, quarter turns.
    wr(angle_abz_pkg::ADDR_PHIGH, 8'h00);
    wr(angle_abz_pkg::ADDR_SHAPE, 8'h00);
    tick(50);
    c0 = pos_cnt;
    b0 = n_bad;
    for (int k = 1; k <= 4; k++) begin
      angle <= 16'(k * 16'h4000);
      tick(60);
      p = k % 4;
      cmp("abz", {13'h0000, p == 0 || p == 3, p >= 2, p < 2}, {13'h0000, quad_a, quad_b, index_z});
    end
    cmp("edges per turn", 16'h0004, pos_cnt - c0);
    cmp("bad edges", 16'h0000, 16'(n_bad - b0));
    // Shape code 0100 narrows the index to one edge, so it is low at phase 1.
    wr(angle_abz_pkg::ADDR_SHAPE, 8'h10);
    angle <= 16'h4000;
    tick(60);
    cmp("narrow index", 16'h0000, {15'h0000, index_z});
    rd(angle_abz_pkg::ADDR_SHAPE, 8'hff, 8'h10);
    rd(angle_abz_pkg::ADDR_PHIGH, 8'hff, 8'h00);
    wr(angle_abz_pkg::ADDR_BCT, 8'h00);
    tick(10);
    close_out();
  end
endmodule : angle_sensor_abz_and_field_flags_bench
`default_nettype wire
